// File: design/atc_pkg.sv
// Shared constants and types for the cell convergence block
package atc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Cell layout
    localparam int CELL_OCTETS = 53;
    localparam logic [5:0] IDX_FIRST = 6'h00;
    localparam logic [5:0] IDX_HEC = 6'h04;
    localparam logic [5:0] IDX_PAY = 6'h05;
    localparam logic [5:0] IDX_LAST = 6'h34;
    localparam logic [5:0] IDX_END = 6'h35;

    ////////////////////////////////////////////////////////////////////////
    // Header check, idle cells and scrambler
    localparam logic [7:0] HEC_COSET = 8'h55;
    localparam logic [7:0] HEC_POLY = 8'h07;
    localparam logic [7:0] CRC_PRESET = 8'h00;
    localparam logic [31:0] IDLE_HDR = 32'h0000_0001;
    localparam logic [7:0] IDLE_FILL = 8'h6a;
    localparam int SCR_TAP = 43;

    ////////////////////////////////////////////////////////////////////////
    // Delineation thresholds
    localparam logic [2:0] SYNC_MISSES = 3'h5;
    localparam logic [2:0] SYNC_HITS = 3'h7;

    // One whole cell, octet 0 is the first on the wire
    typedef logic [CELL_OCTETS-1:0][7:0] atc_cell_t;

endpackage : atc_pkg

// File: design/atc_cell_if.sv
// Cell interface between the ATM layer end and the convergence end
`timescale 1ns/1ps
interface atc_cell_if;

    // Link clocks, both made by the ATM layer end
    logic tx_clk;
    logic rx_clk;
    // Transmit direction
    logic [7:0] tx_cell_data;
    logic tx_cell_first_octet;
    logic tx_enable;
    logic tx_room_available;
    logic tx_network_timing_in;
    // Receive direction
    logic [7:0] rx_cell_data;
    logic rx_cell_first_octet;
    logic rx_octet_valid;
    logic rx_cell_waiting;
    logic rx_enable;
    logic rx_network_timing_out;

    // A second latency path is a second instance of this interface;
    // only the slow path is built here, the fast one is optional
    modport tc (
        input tx_clk, rx_clk, tx_cell_data, tx_cell_first_octet, tx_enable,
        input tx_network_timing_in, rx_enable,
        output tx_room_available, rx_cell_data, rx_cell_first_octet,
        output rx_octet_valid, rx_cell_waiting, rx_network_timing_out
    );
    modport atm (
        output tx_clk, rx_clk, tx_cell_data, tx_cell_first_octet, tx_enable,
        output tx_network_timing_in, rx_enable,
        input tx_room_available, rx_cell_data, rx_cell_first_octet,
        input rx_octet_valid, rx_cell_waiting, rx_network_timing_out
    );

endinterface : atc_cell_if

// File: design/atc_tc_end.sv
// Convergence end: cell ingest, framing, delineation and delivery
`timescale 1ns/1ps
module atc_tc_end
    import atc_pkg::*;
#(
    parameter bit NETWORK_SIDE = 1'b1
)(
    // System reset, caught per link domain
    input wire logic sys_rst_i,
    // Cell interface toward the ATM layer
    atc_cell_if.tc cif,
    // Line side, transmit link clock
    output logic [7:0] line_tx_data_o,
    output logic line_tx_ntr_o,
    // Line side, receive link clock
    input wire logic [7:0] line_rx_data_i,
    input wire logic line_rx_valid_i,
    input wire logic line_rx_ntr_i,
    output logic rx_in_sync_o
);

    typedef enum {DL_HUNT, DL_PRESYNC, DL_SYNC} atc_dlin_e;

    ////////////////////////////////////////////////////////////////////////
    // Octet-wide CRC step, most significant bit first
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            r = {r[6:0], 1'b0} ^ (HEC_POLY & {8{r[7] ^ d[i]}});
        end
        return r;
    endfunction : crc_step

    // Self-synchronising x^43+1 step; returns {history, octet}
    function automatic logic [50:0] scr_step(input logic [42:0] h,
                                             input logic [7:0] d,
                                             input logic dsc);
        logic [42:0] s;
        logic [7:0] o;
        s = h;
        o = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            o[i] = d[i] ^ s[SCR_TAP-1];
            s = {s[41:0], dsc ? d[i] : o[i]};
        end
        return {s, o};
    endfunction : scr_step

    ////////////////////////////////////////////////////////////////////////
    // Transmit domain, clocked by the ATM layer's transmit clock
    logic [1:0] tx_rs_q;
    atc_cell_t tx_buf_q;
    logic [5:0] tx_widx_q;
    logic tx_full_q;
    logic tx_room_q;
    logic [5:0] tx_pos_q;
    logic tx_sel_q;
    logic [7:0] tx_crc_q;
    logic [42:0] tx_scr_q;
    logic [1:0] tx_ns_q;

    wire logic tx_rst = tx_rs_q[1];

    // Ingest decode; a full buffer refuses octets
    wire logic tx_wr = cif.tx_enable && !tx_full_q;
    wire logic [5:0] tx_widx = cif.tx_cell_first_octet ? IDX_FIRST
                                                       : tx_widx_q;
    wire logic tx_head = tx_pos_q == IDX_FIRST;
    wire logic tx_last = tx_pos_q == IDX_LAST;
    // Buffer chosen at each cell boundary, else an idle cell goes out
    wire logic tx_sel = tx_head ? tx_full_q : tx_sel_q;
    wire logic [1:0] tx_p2 = tx_pos_q[1:0];
    wire logic [7:0] tx_idle = (tx_pos_q < IDX_HEC)
        ? 8'(IDLE_HDR >> {~tx_p2, 3'b000}) : IDLE_FILL;
    wire logic [7:0] tx_raw = tx_sel ? tx_buf_q[tx_pos_q] : tx_idle;
    wire logic [7:0] tx_crc = crc_step(tx_head ? CRC_PRESET : tx_crc_q,
                                       tx_raw);
    wire logic [50:0] tx_scr = scr_step(tx_scr_q, tx_raw, 1'b0);
    wire logic tx_full_d = (tx_full_q && !(tx_last && tx_sel))
                        || (tx_wr && tx_widx == IDX_LAST);
    // Octet five from the ATM layer is dropped for the check byte
    wire logic [7:0] tx_octet = (tx_pos_q < IDX_HEC) ? tx_raw
        : (tx_pos_q == IDX_HEC) ? (tx_crc_q ^ HEC_COSET)
        : tx_scr[7:0];

    // Reset catcher; the link clock runs while reset is held
    always_ff @(posedge cif.tx_clk)
        tx_rs_q <= {tx_rs_q[0], sys_rst_i};

    // Cell store, no reset needed: flags guard it
    always_ff @(posedge cif.tx_clk)
        if (tx_wr)
            tx_buf_q[tx_widx] <= cif.tx_cell_data;

    // Transmit control and line framing
    always_ff @(posedge cif.tx_clk)
    begin
        if (tx_rst)
        begin
            tx_widx_q <= IDX_FIRST;
            tx_full_q <= 1'b0;
            tx_room_q <= 1'b0;
            tx_pos_q <= IDX_FIRST;
            tx_sel_q <= 1'b0;
            tx_crc_q <= CRC_PRESET;
            tx_scr_q <= '0;
            tx_ns_q <= 2'b00;
            line_tx_data_o <= 8'h00;
            line_tx_ntr_o <= 1'b0;
        end
        else
        begin
            if (tx_wr)
                tx_widx_q <= tx_widx + 6'h01;
            tx_full_q <= tx_full_d;
            tx_room_q <= !tx_full_d;
            tx_pos_q <= tx_last ? IDX_FIRST : tx_pos_q + 6'h01;
            tx_sel_q <= tx_sel;
            if (tx_pos_q < IDX_HEC)
                tx_crc_q <= tx_crc;
            if (tx_pos_q >= IDX_PAY)
                tx_scr_q <= tx_scr[50:8];
            line_tx_data_o <= tx_octet;
            tx_ns_q <= {tx_ns_q[0], cif.tx_network_timing_in};
            line_tx_ntr_o <= NETWORK_SIDE & tx_ns_q[1];
        end
    end

    assign cif.tx_room_available = tx_room_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive domain, clocked by the ATM layer's receive clock
    logic [1:0] rx_rs_q;
    atc_dlin_e rx_st_q, rx_st_d;
    logic [2:0] rx_cnt_q, rx_cnt_d;
    logic [5:0] rx_pos_q, rx_pos_d;
    logic [31:0] rx_sh_q;
    logic [42:0] rx_dsc_q;
    logic rx_good_q;
    atc_cell_t rx_asm_q;
    atc_cell_t rx_out_q;
    logic rx_full_q;
    logic [5:0] rx_ridx_q;
    logic [7:0] rx_data_q;
    logic rx_first_q;
    logic rx_valid_q;
    logic rx_wait_q;
    logic [1:0] rx_ns_q;
    logic rx_ntr_q;

    wire logic rx_rst = rx_rs_q[1];

    // Header check over the four octets behind the current one
    wire logic [7:0] rx_hec = crc_step(crc_step(crc_step(crc_step(
        CRC_PRESET, rx_sh_q[31:24]), rx_sh_q[23:16]), rx_sh_q[15:8]),
        rx_sh_q[7:0]);
    // Detection only: a bad header is never repaired
    wire logic rx_ok = (rx_hec ^ HEC_COSET) == line_rx_data_i;
    wire logic rx_at_hec = rx_pos_q == IDX_HEC;
    wire logic rx_last = rx_pos_q == IDX_LAST;
    wire logic rx_idle = rx_sh_q == IDLE_HDR;
    wire logic rx_hunt = rx_st_q == DL_HUNT;
    wire logic [50:0] rx_dsc = scr_step(rx_dsc_q, line_rx_data_i, 1'b1);
    wire logic [7:0] rx_octet = (rx_pos_q >= IDX_PAY) ? rx_dsc[7:0]
                                                      : line_rx_data_i;
    // A finished cell is dropped while the delivery buffer is busy
    wire logic rx_load = line_rx_valid_i && rx_last && rx_good_q
                      && rx_st_q == DL_SYNC && !rx_full_q;
    wire logic rx_give = cif.rx_enable && rx_full_q;
    wire logic rx_rlast = rx_ridx_q == IDX_LAST;
    wire logic rx_full_d = rx_load || (rx_full_q && !(rx_give && rx_rlast));
    wire logic [5:0] rx_ridx_d = !rx_give ? rx_ridx_q
        : rx_rlast ? IDX_FIRST : rx_ridx_q + 6'h01;

    // Delineation next state
    always_comb
    begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_pos_d = rx_last ? IDX_FIRST : rx_pos_q + 6'h01;
        case (rx_st_q)
            DL_HUNT:
                if (rx_ok)
                begin
                    rx_st_d = DL_PRESYNC;
                    rx_cnt_d = 3'h0;
                    rx_pos_d = IDX_PAY;
                end
            DL_PRESYNC:
                if (rx_at_hec && !rx_ok)
                    rx_st_d = DL_HUNT;
                else if (rx_at_hec && rx_cnt_q == SYNC_HITS - 3'h1)
                begin
                    rx_st_d = DL_SYNC;
                    rx_cnt_d = 3'h0;
                end
                else if (rx_at_hec)
                    rx_cnt_d = rx_cnt_q + 3'h1;
            DL_SYNC:
                if (rx_at_hec && rx_ok)
                    rx_cnt_d = 3'h0;
                else if (rx_at_hec && rx_cnt_q == SYNC_MISSES - 3'h1)
                begin
                    rx_st_d = DL_HUNT;
                    rx_cnt_d = 3'h0;
                end
                else if (rx_at_hec)
                    rx_cnt_d = rx_cnt_q + 3'h1;
            default:
                rx_st_d = DL_HUNT;
        endcase
    end

    always_ff @(posedge cif.rx_clk)
        rx_rs_q <= {rx_rs_q[0], sys_rst_i};

    // Assembly and delivery stores
    always_ff @(posedge cif.rx_clk)
    begin
        if (line_rx_valid_i && !rx_hunt)
            rx_asm_q[rx_pos_q] <= rx_octet;
        if (rx_load)
        begin
            rx_out_q <= rx_asm_q;
            rx_out_q[IDX_LAST] <= rx_octet;
        end
    end

    // Receive control, delineation and delivery
    always_ff @(posedge cif.rx_clk)
    begin
        if (rx_rst)
        begin
            rx_st_q <= DL_HUNT;
            rx_cnt_q <= 3'h0;
            rx_pos_q <= IDX_FIRST;
            rx_sh_q <= '0;
            rx_dsc_q <= '0;
            rx_good_q <= 1'b0;
            rx_full_q <= 1'b0;
            rx_ridx_q <= IDX_FIRST;
            rx_data_q <= 8'h00;
            rx_first_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_wait_q <= 1'b0;
            rx_ns_q <= 2'b00;
            rx_ntr_q <= 1'b0;
            rx_in_sync_o <= 1'b0;
        end
        else
        begin
            if (line_rx_valid_i)
            begin
                rx_st_q <= rx_st_d;
                rx_cnt_q <= rx_cnt_d;
                rx_pos_q <= rx_pos_d;
                rx_sh_q <= {rx_sh_q[23:0], line_rx_data_i};
                if (!rx_hunt && rx_pos_q >= IDX_PAY)
                    rx_dsc_q <= rx_dsc[50:8];
                if (rx_at_hec)
                    rx_good_q <= rx_st_q == DL_SYNC && rx_ok
                              && !rx_idle;
            end
            rx_full_q <= rx_full_d;
            rx_ridx_q <= rx_ridx_d;
            rx_valid_q <= rx_give;
            rx_data_q <= rx_give ? rx_out_q[rx_ridx_q] : 8'h00;
            rx_first_q <= rx_give && rx_ridx_q == IDX_FIRST;
            rx_wait_q <= rx_full_d && rx_ridx_d == IDX_FIRST;
            rx_in_sync_o <= line_rx_valid_i ? rx_st_d == DL_SYNC
                                            : rx_st_q == DL_SYNC;
            rx_ns_q <= {rx_ns_q[0], line_rx_ntr_i};
            rx_ntr_q <= !NETWORK_SIDE & rx_ns_q[1];
        end
    end

    assign cif.rx_cell_data = rx_data_q;
    assign cif.rx_cell_first_octet = rx_first_q;
    assign cif.rx_octet_valid = rx_valid_q;
    assign cif.rx_cell_waiting = rx_wait_q;
    assign cif.rx_network_timing_out = rx_ntr_q;

endmodule : atc_tc_end

// File: design/atc_atm_end.sv
// ATM layer end: link clock maker, cell sender and cell collector
`timescale 1ns/1ps
module atc_atm_end
    import atc_pkg::*;
(
    // System clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Cell interface toward the convergence end
    atc_cell_if.atm cif,
    // User transmit side
    input wire atc_cell_t usr_tx_cell_i,
    input wire logic usr_tx_req_i,
    output logic usr_tx_busy_o,
    // User receive side
    input wire logic usr_rx_ready_i,
    output atc_cell_t usr_rx_cell_o,
    output logic usr_rx_valid_o,
    // Network timing marker, in at network side, out at customer side
    input wire logic usr_ntr_i,
    output logic usr_ntr_o
);

    typedef enum {TX_IDLE, TX_WAIT, TX_SEND} atc_tx_e;

    ////////////////////////////////////////////////////////////////////////
    // Link clock: half the system rate, free running through reset so
    // the far end can catch the reset on its own clock
    logic lclk_q;

    always_ff @(posedge sys_clk_i)
        if (lclk_q)
            lclk_q <= 1'b0;
        else
            lclk_q <= 1'b1;

    // Drive and sample on the falling half, away from far end edges
    wire logic step = lclk_q;

    assign cif.tx_clk = lclk_q;
    assign cif.rx_clk = lclk_q;

    ////////////////////////////////////////////////////////////////////////
    // Transmit: one cell held, sent only when room is flagged
    atc_tx_e tx_st_q;
    atc_cell_t tx_cell_q;
    logic [5:0] tx_idx_q;
    logic [7:0] tx_data_q;
    logic tx_first_q;
    logic tx_en_q;

    wire logic tx_end = tx_idx_q == IDX_END;

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_st_q <= TX_IDLE;
            tx_idx_q <= IDX_FIRST;
            tx_data_q <= 8'h00;
            tx_first_q <= 1'b0;
            tx_en_q <= 1'b0;
            usr_tx_busy_o <= 1'b0;
        end
        else
        begin
            case (tx_st_q)
                TX_IDLE:
                    if (usr_tx_req_i)
                    begin
                        tx_cell_q <= usr_tx_cell_i;
                        tx_st_q <= TX_WAIT;
                        usr_tx_busy_o <= 1'b1;
                    end
                TX_WAIT:
                    if (step && cif.tx_room_available)
                    begin
                        tx_st_q <= TX_SEND;
                        tx_idx_q <= IDX_FIRST;
                    end
                TX_SEND:
                    if (step && tx_end)
                    begin
                        tx_en_q <= 1'b0;
                        tx_first_q <= 1'b0;
                        tx_st_q <= TX_IDLE;
                        usr_tx_busy_o <= 1'b0;
                    end
                    else if (step)
                    begin
                        tx_data_q <= tx_cell_q[tx_idx_q];
                        tx_first_q <= tx_idx_q == IDX_FIRST;
                        tx_en_q <= 1'b1;
                        tx_idx_q <= tx_idx_q + 6'h01;
                    end
                default:
                    tx_st_q <= TX_IDLE;
            endcase
        end
    end

    assign cif.tx_cell_data = tx_data_q;
    assign cif.tx_cell_first_octet = tx_first_q;
    assign cif.tx_enable = tx_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive: grant follows user readiness, octets gathered by index
    logic rx_en_q;
    logic [5:0] rx_idx_q;

    wire logic rx_take = step && cif.rx_octet_valid;
    wire logic [5:0] rx_idx = cif.rx_cell_first_octet ? IDX_FIRST
                                                      : rx_idx_q;

    always_ff @(posedge sys_clk_i)
        if (rx_take)
            usr_rx_cell_o[rx_idx] <= cif.rx_cell_data;

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            rx_en_q <= 1'b0;
            rx_idx_q <= IDX_FIRST;
            usr_rx_valid_o <= 1'b0;
        end
        else
        begin
            if (step)
                rx_en_q <= usr_rx_ready_i;
            if (rx_take)
                rx_idx_q <= rx_idx + 6'h01;
            usr_rx_valid_o <= rx_take && rx_idx == IDX_LAST;
        end
    end

    assign cif.rx_enable = rx_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Timing marker: 8 kHz levels, three flops each way
    logic [1:0] ntr_in_q;
    logic ntr_tx_q;
    logic [1:0] ntr_out_q;

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            ntr_in_q <= 2'b00;
            ntr_tx_q <= 1'b0;
            ntr_out_q <= 2'b00;
            usr_ntr_o <= 1'b0;
        end
        else
        begin
            ntr_in_q <= {ntr_in_q[0], usr_ntr_i};
            ntr_tx_q <= ntr_in_q[1];
            ntr_out_q <= {ntr_out_q[0], cif.rx_network_timing_out};
            usr_ntr_o <= ntr_out_q[1];
        end
    end

    assign cif.tx_network_timing_in = ntr_tx_q;

endmodule : atc_atm_end

// File: verif/atc_link_checker.sv
// Link handshake assertions for the cell interface
`timescale 1ns/1ps
module atc_link_checker (
    // Reset and link clocks
    input wire logic sys_rst_i,
    input wire logic tx_clk,
    input wire logic rx_clk,
    // Transmit handshake
    input wire logic tx_cell_first_octet,
    input wire logic tx_enable,
    input wire logic tx_room_available,
    // Receive handshake
    input wire logic rx_cell_first_octet,
    input wire logic rx_octet_valid,
    input wire logic rx_cell_waiting,
    input wire logic rx_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Steps of one transmit cell
    sequence s_tx_body;
        (tx_enable && !tx_cell_first_octet) [*8];
    endsequence
    sequence s_tx_end;
        !tx_room_available && !tx_enable;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Transmit side
    property p_tx_first;
        @(posedge tx_clk) disable iff (sys_rst_i)
        tx_cell_first_octet |-> tx_enable && tx_room_available;
    endproperty
    a_tx_first: assert property (p_tx_first)
        else $error("cell start without enable or room");
    property p_tx_body;
        @(posedge tx_clk) disable iff (sys_rst_i)
        tx_cell_first_octet |=> s_tx_body;
    endproperty
    a_tx_body: assert property (p_tx_body)
        else $error("transmit cell octets not back to back");
    property p_tx_full;
        @(posedge tx_clk) disable iff (sys_rst_i)
        tx_cell_first_octet |-> ##53 s_tx_end;
    endproperty
    a_tx_full: assert property (p_tx_full)
        else $error("room flag still up after a whole cell");
    // Room must stay down for eight cycles once it falls
    property p_room_hold;
        @(posedge tx_clk) disable iff (sys_rst_i)
        $fell(tx_room_available) |-> !tx_room_available [*8];
    endproperty
    a_room_hold: assert property (p_room_hold)
        else $error("room flag returned too early");

    ////////////////////////////////////////////////////////////////////////
    // Receive side
    property p_rx_marker;
        @(posedge rx_clk) disable iff (sys_rst_i)
        rx_cell_first_octet |-> rx_octet_valid;
    endproperty
    a_rx_marker: assert property (p_rx_marker)
        else $error("receive marker without valid octet");
    property p_rx_grant;
        @(posedge rx_clk) disable iff (sys_rst_i)
        rx_octet_valid |-> $past(rx_enable);
    endproperty
    a_rx_grant: assert property (p_rx_grant)
        else $error("octet delivered without grant");
    property p_rx_start;
        @(posedge rx_clk) disable iff (sys_rst_i)
        rx_cell_waiting && rx_enable |=>
            rx_cell_first_octet && rx_octet_valid && !rx_cell_waiting;
    endproperty
    a_rx_start: assert property (p_rx_start)
        else $error("waiting cell not started on grant");
    property p_rx_next;
        @(posedge rx_clk) disable iff (sys_rst_i)
        rx_cell_first_octet && rx_enable |=>
            rx_octet_valid && !rx_cell_first_octet;
    endproperty
    a_rx_next: assert property (p_rx_next)
        else $error("second octet of cell missing");

endmodule : atc_link_checker

// File: verif/tb_top.sv
// Loopback bench: user cells through both ends and back over the line
`timescale 1ns/1ps
module tb_top
    import atc_pkg::*;
;
    // Stimulus and observed outputs
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    atc_cell_t usr_tx_cell_i = '0;
    logic usr_tx_req_i = 1'b0;
    logic usr_rx_ready_i = 1'b1;
    logic usr_ntr_i = 1'b0;
    logic [7:0] err_mask = 8'h00;
    logic usr_tx_busy_o, usr_rx_valid_o, rx_in_sync_o, line_tx_ntr;
    atc_cell_t usr_rx_cell_o;
    logic [7:0] line_tx_data;
    atc_cell_t exp_q[$];
    int bad_count = 0;
    int n_compared = 0;
    int n_delivered = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    ////////////////////////////////////////////////////////////////////////
    // Both ends; line looped back through an error mask
    atc_cell_if atc_cell_if_inst ();
    atc_atm_end atc_atm_end_inst (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .cif(atc_cell_if_inst.atm),
        .usr_tx_cell_i(usr_tx_cell_i), .usr_tx_req_i(usr_tx_req_i),
        .usr_tx_busy_o(usr_tx_busy_o), .usr_rx_ready_i(usr_rx_ready_i),
        .usr_rx_cell_o(usr_rx_cell_o), .usr_rx_valid_o(usr_rx_valid_o),
        .usr_ntr_i(usr_ntr_i), .usr_ntr_o());
    atc_tc_end #(.NETWORK_SIDE(1'b1)) atc_tc_end_inst (
        .sys_rst_i(sys_rst_i), .cif(atc_cell_if_inst.tc),
        .line_tx_data_o(line_tx_data), .line_tx_ntr_o(line_tx_ntr),
        .line_rx_data_i(line_tx_data ^ err_mask), .line_rx_valid_i(1'b1),
        .line_rx_ntr_i(line_tx_ntr), .rx_in_sync_o(rx_in_sync_o));
    atc_link_checker atc_link_checker_inst (.sys_rst_i(sys_rst_i),
        .tx_clk(atc_cell_if_inst.tx_clk), .rx_clk(atc_cell_if_inst.rx_clk),
        .tx_cell_first_octet(atc_cell_if_inst.tx_cell_first_octet),
        .tx_enable(atc_cell_if_inst.tx_enable),
        .tx_room_available(atc_cell_if_inst.tx_room_available),
        .rx_cell_first_octet(atc_cell_if_inst.rx_cell_first_octet),
        .rx_octet_valid(atc_cell_if_inst.rx_octet_valid),
        .rx_cell_waiting(atc_cell_if_inst.rx_cell_waiting),
        .rx_enable(atc_cell_if_inst.rx_enable));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [CELL_OCTETS*8-1:0] seen,
                         input logic [CELL_OCTETS*8-1:0] want);
        n_compared++;
        if (seen !== want)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Own reference check byte, bitwise and MSB first
    function automatic logic [7:0] hec_of(input logic [31:0] h);
        logic [7:0] c;
        c = CRC_PRESET;
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? HEC_POLY : 8'h00);
        return c ^ HEC_COSET;
    endfunction : hec_of

    function automatic atc_cell_t rand_cell(input logic [31:0] hdr);
        atc_cell_t c;
        for (int j = 0; j < CELL_OCTETS; j++)
            c[j] = 8'($urandom);
        {c[0], c[1], c[2], c[3]} = hdr;
        return c;
    endfunction : rand_cell

    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 2000 && usr_tx_busy_o !== lvl; i++)
            @(negedge sys_clk_i);
        check(usr_tx_busy_o, lvl);
        if (usr_tx_busy_o !== lvl)
            tally_and_finish();
    endtask : wait_busy

    task automatic wait_sync(input logic lvl, input int lim);
        for (int i = 0; i < lim && rx_in_sync_o !== lvl; i++)
            @(negedge sys_clk_i);
        check(rx_in_sync_o, lvl);
        if (rx_in_sync_o !== lvl)
            tally_and_finish();
    endtask : wait_sync

    // Expected copy carries the check byte in octet five
    task automatic send_cell(input atc_cell_t c, input bit keep);
        atc_cell_t e;
        e = c;
        e[4] = hec_of({c[0], c[1], c[2], c[3]});
        wait_busy(1'b0);
        usr_tx_cell_i = c;
        usr_tx_req_i = 1'b1;
        if (keep)
            exp_q.push_back(e);
        wait_busy(1'b1);
        usr_tx_req_i = 1'b0;
    endtask : send_cell

    task automatic drain();
        for (int i = 0; i < 3000 && exp_q.size() != 0; i++)
            @(negedge sys_clk_i);
        check(exp_q.size() == 0, 1'b1);
        if (exp_q.size() != 0)
            tally_and_finish();
    endtask : drain

    ////////////////////////////////////////////////////////////////////////
    // Watcher: any delivery must match the oldest note
    always @(negedge sys_clk_i)
    begin
        if (sys_rst_i === 1'b0 && usr_rx_valid_o === 1'b1)
        begin
            n_delivered++;
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else
                check(usr_rx_cell_o, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int held;
        void'($urandom(32'h8c51));
        repeat (16) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        wait_sync(1'b1, 3000);
        usr_ntr_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        check(line_tx_ntr, 1'b1);
        check(atc_cell_if_inst.rx_network_timing_out, 1'b0);
        usr_ntr_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        check(line_tx_ntr, 1'b0);
        $display("test sync_and_timing done");
        // Back to back, headers on both sides of the idle header
        send_cell(rand_cell(32'h0000_0000), 1'b1);
        send_cell(rand_cell(IDLE_HDR), 1'b0);
        send_cell(rand_cell(32'hffff_ffff), 1'b1);
        for (int k = 0; k < 6; k++)
            send_cell(rand_cell(32'($urandom) | 32'h1000_0000), 1'b1);
        drain();
        $display("test back_to_back done");
        // Delivery held back while the grant is low
        usr_rx_ready_i = 1'b0;
        held = n_delivered;
        send_cell(rand_cell(32'h0a0b_0c0d), 1'b1);
        repeat (400) @(negedge sys_clk_i);
        check(n_delivered == held, 1'b1);
        check(atc_cell_if_inst.rx_cell_waiting, 1'b1);
        usr_rx_ready_i = 1'b1;
        drain();
        $display("test grant done");
        // Few bad headers: cell dropped, sync kept
        send_cell(rand_cell(32'h5555_aaaa), 1'b0);
        wait_busy(1'b0);
        err_mask = 8'h01;
        repeat (318) @(negedge sys_clk_i);
        err_mask = 8'h00;
        check(rx_in_sync_o, 1'b1);
        repeat (300) @(negedge sys_clk_i);
        send_cell(rand_cell(32'h1234_5678), 1'b1);
        drain();
        $display("test short_errors done");
        // Long burst loses sync; clean line regains it
        err_mask = 8'h01;
        repeat (400) @(negedge sys_clk_i);
        check(rx_in_sync_o, 1'b1);
        wait_sync(1'b0, 400);
        err_mask = 8'h00;
        repeat (690) @(negedge sys_clk_i);
        check(rx_in_sync_o, 1'b0);
        wait_sync(1'b1, 3000);
        send_cell(rand_cell(32'hffff_fff0), 1'b1);
        drain();
        $display("test resync done");
        tally_and_finish();
    end

endmodule : tb_top
